/* inc/hvw_consts.vh */
// Constants for the high-voltage wake input monitor: register offsets,
// field positions, reset values and filter timing.
// Assumes a 200 MHz system clock standing in for the internal oscillator.
`ifndef HVW_CONSTS_VH
`define HVW_CONSTS_VH

// Register offsets (word index on the plain register port)
`define HVW_ADDR_WAKE_ENABLE  4'h0
`define HVW_ADDR_PULL_SOURCE  4'h1
`define HVW_ADDR_FILTER_MODE  4'h2
`define HVW_ADDR_MEASURE      4'h3
`define HVW_ADDR_WAKE_STAT1   4'h4
`define HVW_ADDR_WAKE_STAT2   4'h5
`define HVW_ADDR_LEVEL_STAT   4'h6
`define HVW_ADDR_CMD_STAT     4'h7

// Field positions
`define HVW_ALT_ENABLE_BIT    3
`define HVW_ALT_ENABLE_BIT2   4

// Reset values
`define HVW_PULL_RESET        6'h00
`define HVW_FILTER_RESET      6'h00
`define HVW_WAKE_EN_RESET     5'h00

// Filter selector codes
`define HVW_FLT_STATIC_SHORT  2'h0
`define HVW_FLT_STATIC_LONG   2'h1
`define HVW_FLT_CYCLIC_A      2'h2
`define HVW_FLT_CYCLIC_B      2'h3

// Pull source codes
`define HVW_PULL_NONE         2'h0
`define HVW_PULL_DOWN         2'h1
`define HVW_PULL_UP           2'h2
`define HVW_PULL_AUTO         2'h3

// Device modes
`define HVW_MODE_NORMAL       3'h0
`define HVW_MODE_STOP         3'h1
`define HVW_MODE_SLEEP        3'h2
`define HVW_MODE_FAILSAFE     3'h3
`define HVW_MODE_RESTART      3'h4

// Filter timing
`define HVW_CLK_MHZ           200
`define HVW_FILTER_SHORT_US   16
`define HVW_FILTER_LONG_US    64
`define HVW_FILTER_SHORT_CYC  (`HVW_FILTER_SHORT_US * `HVW_CLK_MHZ)
`define HVW_FILTER_LONG_CYC   (`HVW_FILTER_LONG_US * `HVW_CLK_MHZ)

`endif

/* rtl/hvw_edge_filter.v */
// One wake input channel: edge filter with selectable interval.
// Assumes the comparator level is already synchronous to clk_sys.
`timescale 1ns/1ps
`include "hvw_consts.vh"

module hvw_edge_filter #(
  parameter CNT_W     = 14,
  parameter SHORT_CYC = `HVW_FILTER_SHORT_CYC,
  parameter LONG_CYC  = `HVW_FILTER_LONG_CYC
) (
  input  wire       clk_sys,     // system clock
  input  wire       rst_n,       // async reset, active low
  input  wire       level_in,    // comparator level
  input  wire       sense_on,    // evaluation window open
  input  wire       long_sel,    // choose the long interval
  output reg        level_reg,   // filtered stable level
  output reg        edge_reg     // one-cycle pulse on accepted edge
);

  reg [CNT_W-1:0] count_reg;
  reg             busy_reg;
  wire [CNT_W-1:0] limit = long_sel ? LONG_CYC[CNT_W-1:0] : SHORT_CYC[CNT_W-1:0];

  // Any crossing restarts the interval; only a quiet interval is accepted
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= {CNT_W{1'b0}};
      busy_reg  <= 1'b0;
      level_reg <= 1'b0;
      edge_reg  <= 1'b0;
    end else begin
      edge_reg <= 1'b0;
      if (!sense_on) begin
        // Closed window abandons a pending edge, keeps last level
        busy_reg  <= 1'b0;
        count_reg <= {CNT_W{1'b0}};
      end else if (level_in != level_reg) begin
        if (!busy_reg || level_in != level_reg) begin
          busy_reg <= 1'b1;
        end
        if (busy_reg && count_reg + 1'b1 >= limit) begin
          level_reg <= level_in;
          edge_reg  <= 1'b1;
          busy_reg  <= 1'b0;
          count_reg <= {CNT_W{1'b0}};
        end else begin
          count_reg <= busy_reg ? count_reg + 1'b1 : {CNT_W{1'b0}};
        end
      end else begin
        // Input crossed back before the interval ended: discard
        busy_reg  <= 1'b0;
        count_reg <= {CNT_W{1'b0}};
      end
    end
  end

endmodule

/* rtl/hvw_wake_monitor.v */
// Wake input monitor: three wake pins, two alternate output wake pins,
// pull sources, measurement switch and wake/level status registers.
// Assumes mode, timer windows and sleep request come from the mode logic.
// Function
// - Both edge directions are wake events
// - Interrupt in normal/stop, wake in sleep/failsafe
// - Edge accepted only after quiet filter interval
// - Filter selector picks interval and sense timer
// - Cyclic sense evaluates only in timer window
// - Per-pin wake enable bit
// - Per-pin wake flag in first status
// - Level status shown in normal and stop
// - Cyclic level is last window sample
// - Alternate pins: fixed short filter, second status
// - Pull selector: none, down, up, auto
// - Auto pull follows detected level
// - Measure enable resets to zero
// - Measure switch closed only in normal
// - Measure disables pulls and gates wakes on the first two pins
// - Gated settings still writable, no effect
// - Gated pins leave status unchanged
// - Sleep with only gated sources fails
// - Wake flags stick until software clears
`timescale 1ns/1ps
`include "hvw_consts.vh"

module hvw_wake_monitor #(
  parameter CNT_W = 14
) (
  input  wire       clk_sys,          // system clock, 200 MHz
  input  wire       rst_n,            // async reset, active low
  input  wire [3:0] reg_addr,         // register word index
  input  wire [7:0] reg_wdata,        // write data
  input  wire       reg_wr,           // write strobe
  input  wire       reg_rd,           // read strobe
  input  wire [2:0] device_mode,      // current device mode
  input  wire       timer_a_window,   // cyclic timer A active window
  input  wire       timer_b_window,   // cyclic timer B active window
  input  wire       sleep_request,    // one-cycle sleep command
  input  wire [2:0] wake_pin_level,   // comparator levels of three pins
  input  wire [1:0] alt_pin_level,    // levels of alternate output pins
  input  wire [1:0] alt_pin_as_wake,  // alternate pins configured as wake
  output reg  [7:0] reg_rdata,        // read data, cycle after read
  output reg  [2:0] pull_up_on,       // pull-up source enables
  output reg  [2:0] pull_down_on,     // pull-down source enables
  output reg        measurement_switch, // measurement switch closed
  output reg        wake_irq_pulse,   // event in normal/stop
  output reg        wake_up_pulse,    // event in sleep/failsafe
  output reg        cmd_fail_reg,     // serial command failure flag
  output reg        restart_req       // request restart mode, pulse
);

  // Software-visible configuration
  reg [4:0] wake_enable_control_reg;   // [2:0] pins, [4:3] alternate pins
  reg [5:0] pull_source_control_reg;
  reg [5:0] filter_mode_control_reg;
  reg       measure_mode_enable_reg;
  reg [2:0] wake_status_first_reg;
  reg [1:0] wake_status_second_reg;
  reg [2:0] pin_level_status_reg;
  reg       cmd_fail_seen_reg;

  wire [2:0] filt_level;
  wire [2:0] filt_edge;
  wire [1:0] alt_level;
  wire [1:0] alt_edge;
  reg  [2:0] sense_on;
  reg  [2:0] gated;
  reg  [2:0] pin_event;
  reg  [1:0] alt_event;
  reg  [2:0] level_upd;
  integer    i;
  integer    j;
  integer    k;

  // Two-bit field of a packed per-pin vector
  function [1:0] field2;
    input [5:0] vec;
    input [1:0] idx;
    begin
      field2 = vec[idx*2 +: 2];
    end
  endfunction

  wire normal_or_stop = (device_mode == `HVW_MODE_NORMAL) || (device_mode == `HVW_MODE_STOP);
  wire sleepish       = (device_mode == `HVW_MODE_SLEEP) || (device_mode == `HVW_MODE_FAILSAFE);

  // Sense window and gating per pin
  always @* begin
    sense_on = 3'h0;
    gated    = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      case (field2(filter_mode_control_reg, i[1:0]))
        `HVW_FLT_CYCLIC_A: sense_on[i] = timer_a_window;
        `HVW_FLT_CYCLIC_B: sense_on[i] = timer_b_window;
        default:           sense_on[i] = 1'b1;
      endcase
      // Measurement takes over the first two pins
      gated[i] = measure_mode_enable_reg && (i < 2);
    end
  end

  // Three wake pin filters
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : pin_ch
      hvw_edge_filter #(
        .CNT_W (CNT_W)
      ) u_filt (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .level_in  (wake_pin_level[g]),
        .sense_on  (sense_on[g] & ~gated[g]),
        .long_sel  (filter_mode_control_reg[g*2 +: 2] == `HVW_FLT_STATIC_LONG),
        .level_reg (filt_level[g]),
        .edge_reg  (filt_edge[g])
      );
    end
    // Alternate pins always use the short static filter
    for (g = 0; g < 2; g = g + 1) begin : alt_ch
      hvw_edge_filter #(
        .CNT_W (CNT_W)
      ) u_filt (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .level_in  (alt_pin_level[g]),
        .sense_on  (alt_pin_as_wake[g]),
        .long_sel  (1'b0),
        .level_reg (alt_level[g]),
        .edge_reg  (alt_edge[g])
      );
    end
  endgenerate

  // Qualified events and level update enables
  always @* begin
    pin_event = filt_edge & ~gated & wake_enable_control_reg[2:0];
    alt_event = alt_edge & alt_pin_as_wake & wake_enable_control_reg[4:3];
    level_upd = ~gated & {3{normal_or_stop}};
  end

  // Sleep check: only gated pins enabled as sources
  wire only_gated_src = measure_mode_enable_reg && (wake_enable_control_reg[1:0] != 2'h0) &&
                        !wake_enable_control_reg[2] && (wake_enable_control_reg[4:3] == 2'h0);

  // Register writes and sticky status; set beats clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_enable_control_reg <= `HVW_WAKE_EN_RESET;
      pull_source_control_reg <= `HVW_PULL_RESET;
      filter_mode_control_reg <= `HVW_FILTER_RESET;
      measure_mode_enable_reg <= 1'b0;
      wake_status_first_reg   <= 3'h0;
      wake_status_second_reg  <= 2'h0;
      pin_level_status_reg    <= 3'h0;
      cmd_fail_seen_reg       <= 1'b0;
    end else begin
      // Gated pin settings stay writable; gating ignores them
      if (reg_wr) begin
        case (reg_addr)
          `HVW_ADDR_WAKE_ENABLE: wake_enable_control_reg <= reg_wdata[4:0];
          `HVW_ADDR_PULL_SOURCE: pull_source_control_reg <= reg_wdata[5:0];
          `HVW_ADDR_FILTER_MODE: filter_mode_control_reg <= reg_wdata[5:0];
          `HVW_ADDR_MEASURE:     measure_mode_enable_reg <= reg_wdata[0];
          default: ;
        endcase
      end
      // Write one to clear, event in same cycle wins
      wake_status_first_reg <= (wake_status_first_reg &
        ~((reg_wr && reg_addr == `HVW_ADDR_WAKE_STAT1) ? reg_wdata[2:0] : 3'h0)) | pin_event;
      wake_status_second_reg <= (wake_status_second_reg &
        ~((reg_wr && reg_addr == `HVW_ADDR_WAKE_STAT2) ? reg_wdata[1:0] : 2'h0)) | alt_event;
      cmd_fail_seen_reg <= (cmd_fail_seen_reg &
        ~(reg_wr && reg_addr == `HVW_ADDR_CMD_STAT && reg_wdata[0])) | (sleep_request && only_gated_src);
      // Level follows filter; in cyclic sense it holds the last window sample
      for (j = 0; j < 3; j = j + 1) begin
        if (level_upd[j]) begin
          pin_level_status_reg[j] <= filt_level[j];
        end
      end
    end
  end

  // Outputs, all registered
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata          <= 8'h00;
      pull_up_on         <= 3'h0;
      pull_down_on       <= 3'h0;
      measurement_switch <= 1'b0;
      wake_irq_pulse     <= 1'b0;
      wake_up_pulse      <= 1'b0;
      cmd_fail_reg       <= 1'b0;
      restart_req        <= 1'b0;
    end else begin
      // Read data one cycle after the strobe, else zero
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `HVW_ADDR_WAKE_ENABLE: reg_rdata <= {3'h0, wake_enable_control_reg};
          `HVW_ADDR_PULL_SOURCE: reg_rdata <= {2'h0, pull_source_control_reg};
          `HVW_ADDR_FILTER_MODE: reg_rdata <= {2'h0, filter_mode_control_reg};
          `HVW_ADDR_MEASURE:     reg_rdata <= {7'h00, measure_mode_enable_reg};
          `HVW_ADDR_WAKE_STAT1:  reg_rdata <= {5'h00, wake_status_first_reg};
          `HVW_ADDR_WAKE_STAT2:  reg_rdata <= {6'h00, wake_status_second_reg};
          `HVW_ADDR_LEVEL_STAT:  reg_rdata <= {5'h00, pin_level_status_reg};
          `HVW_ADDR_CMD_STAT:    reg_rdata <= {7'h00, cmd_fail_seen_reg};
          default:               reg_rdata <= 8'h00;
        endcase
      end
      // Pull sources; auto follows filtered level
      for (k = 0; k < 3; k = k + 1) begin
        case (field2(pull_source_control_reg, k[1:0]))
          `HVW_PULL_DOWN: begin
            pull_up_on[k]   <= 1'b0;
            pull_down_on[k] <= ~gated[k];
          end
          `HVW_PULL_UP: begin
            pull_up_on[k]   <= ~gated[k];
            pull_down_on[k] <= 1'b0;
          end
          `HVW_PULL_AUTO: begin
            pull_up_on[k]   <= ~gated[k] & filt_level[k];
            pull_down_on[k] <= ~gated[k] & ~filt_level[k];
          end
          default: begin
            pull_up_on[k]   <= 1'b0;
            pull_down_on[k] <= 1'b0;
          end
        endcase
      end
      // Switch closes only in normal mode so low-power modes draw no divider current
      measurement_switch <= measure_mode_enable_reg && (device_mode == `HVW_MODE_NORMAL);
      // Event routing by mode
      wake_irq_pulse <= normal_or_stop && ((|pin_event) || (|alt_event));
      wake_up_pulse  <= sleepish && ((|pin_event) || (|alt_event));
      cmd_fail_reg   <= (cmd_fail_seen_reg &
        ~(reg_wr && reg_addr == `HVW_ADDR_CMD_STAT && reg_wdata[0])) | (sleep_request && only_gated_src);
      restart_req    <= sleep_request && only_gated_src;
    end
  end

endmodule

/* verification/hvw_wake_monitor_props.sv */
// Checker on the wake monitor top ports.
// Assumes clk_sys at 200 MHz and the 3200-cycle short filter.
`timescale 1ns/1ps
module hvw_props #(
  parameter CNT_W = 14
) (
  input wire logic       clk_sys,            // clock
  input wire logic       rst_n,              // reset, low
  input wire logic       reg_rd,             // read strobe
  input wire logic [7:0] reg_rdata,          // read data
  input wire logic [2:0] device_mode,        // mode
  input wire logic       sleep_request,      // sleep command
  input wire logic [2:0] wake_pin_level,     // wake pins
  input wire logic [1:0] alt_pin_level,      // alternate pins
  input wire logic [2:0] pull_up_on,         // pull-ups
  input wire logic [2:0] pull_down_on,       // pull-downs
  input wire logic       measurement_switch, // switch closed
  input wire logic       wake_irq_pulse,     // interrupt pulse
  input wire logic       wake_up_pulse,      // wake pulse
  input wire logic       cmd_fail_reg,       // command fail
  input wire logic       restart_req         // restart pulse
);
  localparam int QUIET = 3190;
  logic [4:0]  pins_prev;
  logic [15:0] quiet_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Cycles since any pin moved; saturates so it never wraps into a false quiet
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev <= 5'h00;
      quiet_cnt <= 16'h0000;
    end else begin
      pins_prev <= {alt_pin_level, wake_pin_level};
      if (pins_prev != {alt_pin_level, wake_pin_level}) begin
        quiet_cnt <= 16'h0000;
      end else if (quiet_cnt != 16'hFFFF) begin
        quiet_cnt <= quiet_cnt + 16'h0001;
      end
    end
  end
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  irq_mode_a: assert property (wake_irq_pulse |-> $past(device_mode) <= 3'h1)
    else $error("interrupt pulse outside normal or stop");
  wake_mode_a: assert property (wake_up_pulse |-> $past(device_mode) inside {3'h2, 3'h3})
    else $error("wake pulse outside sleep or failsafe");
  pulse_excl_a: assert property (!(wake_irq_pulse && wake_up_pulse))
    else $error("interrupt and wake together");
  filter_quiet_a: assert property ((wake_irq_pulse || wake_up_pulse) |-> quiet_cnt >= QUIET)
    else $error("event before the filter interval");
  pull_excl_a: assert property ((pull_up_on & pull_down_on) == 3'h0)
    else $error("pull-up and pull-down both on");
  meas_mode_a: assert property (device_mode != 3'h0 |=> !measurement_switch)
    else $error("switch closed outside normal");
  meas_pull_a: assert property (measurement_switch [*3] |-> (pull_up_on[1:0] | pull_down_on[1:0]) == 2'h0)
    else $error("pulls on while measuring");
  restart_cause_a: assert property (restart_req |-> $past(sleep_request) || $past(sleep_request, 2))
    else $error("restart without sleep command");
  fail_flag_a: assert property (restart_req |-> ##[0:2] cmd_fail_reg)
    else $error("restart without fail flag");
  cover property (wake_irq_pulse);
  cover property (wake_up_pulse);
  cover property (restart_req);
  cover property (measurement_switch);
endmodule
bind hvw_wake_monitor hvw_props #(.CNT_W(CNT_W)) hvw_props_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .device_mode(device_mode), .sleep_request(sleep_request), .wake_pin_level(wake_pin_level),
  .alt_pin_level(alt_pin_level), .pull_up_on(pull_up_on), .pull_down_on(pull_down_on),
  .measurement_switch(measurement_switch), .wake_irq_pulse(wake_irq_pulse),
  .wake_up_pulse(wake_up_pulse), .cmd_fail_reg(cmd_fail_reg), .restart_req(restart_req));

/* verification/hvw_switch_model.sv */
// Switches and sensors on the wake and alternate pins.
// Assumes the bench opens or closes each switch; open pins follow the pulls.
`timescale 1ns/1ps
module hvw_switch_model (
  input  wire logic       clk_sys,            // clock
  input  wire logic [4:0] sw_closed,          // switch closed per pin
  input  wire logic [4:0] sw_level,           // level of a closed switch
  input  wire logic [2:0] pull_up_on,         // pull-ups
  input  wire logic [2:0] pull_down_on,       // pull-downs
  output logic      [2:0] wake_pin_level,     // wake pin levels
  output logic      [1:0] alt_pin_level       // alternate pin levels
);
  logic [4:0] pin_q = 5'h00;
  wire  [4:0] pu = {2'b00, pull_up_on};
  wire  [4:0] pd = {2'b00, pull_down_on};
  // An open unpulled pin wanders each cycle, never a settled guess
  always @(posedge clk_sys) begin
    for (int i = 0; i < 5; i++) begin
      if (sw_closed[i]) pin_q[i] <= sw_level[i];
      else if (pu[i]) pin_q[i] <= 1'b1;
      else if (pd[i]) pin_q[i] <= 1'b0;
      else pin_q[i] <= ~pin_q[i];
    end
  end
  assign {alt_pin_level, wake_pin_level} = pin_q;
endmodule

/* verification/hvw_wake_monitor_tb_top.sv */
// Self-checking bench for the wake monitor, switch model on its pins.
// Assumes the full 3200 and 12800 cycle filter counts.
`timescale 1ns/1ps
`include "hvw_consts.vh"
module hvw_wake_monitor_tb_top;
  typedef struct {int idx; logic lvl; logic [2:0] mode; logic [7:0] en; logic irq; logic wk; int cyc;} hvw_row_t;
  logic       clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sleep_request = 1'b0;
  logic       timer_a_window = 1'b0, timer_b_window = 1'b0;
  logic [3:0] reg_addr = 4'h0, sa;
  logic [7:0] reg_wdata = 8'h00, got, sx;
  logic [2:0] device_mode = `HVW_MODE_NORMAL, lvls = 3'h0;
  logic [1:0] alt_pin_as_wake = 2'h0;
  logic [4:0] sw_closed = 5'h1F, drv = 5'h00;
  logic [2:0] wake_pin_level, pull_up_on, pull_down_on;
  logic [1:0] alt_pin_level;
  logic [7:0] reg_rdata;
  logic       measurement_switch, wake_irq_pulse, wake_up_pulse, cmd_fail_reg, restart_req;
  logic       irq_seen, wk_seen, rst_seen;
  int         failures = 0, checked = 0;
  // Ordinary edges: pin, level, mode, enables, interrupt, wake, wait
  hvw_row_t rows [7] = '{'{0, 1'b1, 3'h0, 8'h1F, 1'b1, 1'b0, 3400}, '{1, 1'b1, 3'h1, 8'h1F, 1'b1, 1'b0, 13000},
    '{2, 1'b1, 3'h2, 8'h1F, 1'b0, 1'b1, 3400}, '{0, 1'b0, 3'h3, 8'h1F, 1'b0, 1'b1, 3400},
    '{2, 1'b0, 3'h0, 8'h1B, 1'b0, 1'b0, 3400}, '{3, 1'b1, 3'h0, 8'h1F, 1'b1, 1'b0, 3400},
    '{4, 1'b1, 3'h1, 8'h0F, 1'b0, 1'b0, 3400}};
  always #2.5 clk_sys = ~clk_sys;
  hvw_wake_monitor hvw_wake_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .device_mode(device_mode),
    .timer_a_window(timer_a_window), .timer_b_window(timer_b_window), .sleep_request(sleep_request),
    .wake_pin_level(wake_pin_level), .alt_pin_level(alt_pin_level), .alt_pin_as_wake(alt_pin_as_wake),
    .reg_rdata(reg_rdata), .pull_up_on(pull_up_on), .pull_down_on(pull_down_on),
    .measurement_switch(measurement_switch), .wake_irq_pulse(wake_irq_pulse), .wake_up_pulse(wake_up_pulse),
    .cmd_fail_reg(cmd_fail_reg), .restart_req(restart_req));
  hvw_switch_model hvw_switch_model_inst (.clk_sys(clk_sys), .sw_closed(sw_closed),
    .sw_level(drv), .pull_up_on(pull_up_on), .pull_down_on(pull_down_on),
    .wake_pin_level(wake_pin_level), .alt_pin_level(alt_pin_level));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Clock cycles while collecting the one-cycle pulses
  task automatic run(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      irq_seen = irq_seen | (wake_irq_pulse === 1'b1);
      wk_seen = wk_seen | (wake_up_pulse === 1'b1);
      rst_seen = rst_seen | (restart_req === 1'b1);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #450000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    run(2);
    chk({pull_up_on, pull_down_on, measurement_switch}, 8'h00);
    wr(4'h8, 8'hFF);
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], got);
      chk(got, 8'h00);
    end
    wr(`HVW_ADDR_PULL_SOURCE, 8'h24);
    sw_closed <= 5'h1D; // Open pin two on its pull-down
    run(50);
    chk({pull_up_on, pull_down_on}, 8'h22);
    sw_closed <= 5'h1F;
    wr(`HVW_ADDR_PULL_SOURCE, 8'h3F);
    wr(`HVW_ADDR_FILTER_MODE, 8'h04);
    alt_pin_as_wake <= 2'h3;
    foreach (rows[i]) begin
      device_mode <= rows[i].mode;
      wr(`HVW_ADDR_WAKE_ENABLE, rows[i].en);
      irq_seen = 1'b0;
      wk_seen = 1'b0;
      drv[rows[i].idx] <= rows[i].lvl;
      run(rows[i].cyc);
      chk(irq_seen, rows[i].irq);
      chk(wk_seen, rows[i].wk);
      chk(pull_up_on, drv[2:0]);
      if (rows[i].mode <= 3'h1) lvls = drv[2:0];
      sa = rows[i].idx < 3 ? 4'h4 : 4'h5;
      sx = (rows[i].irq | rows[i].wk) ? 8'h01 << (rows[i].idx % 3) : 8'h00;
      rd(sa, got);
      chk(got, sx);
      rd(sa, got);
      chk(got, sx);
      wr(sa, 8'hFF);
      rd(sa, got);
      chk(got, 8'h00);
      rd(`HVW_ADDR_LEVEL_STAT, got);
      chk(got & 8'h07, lvls);
    end
    // Glitches: short on pin one, between the two intervals on pin two
    for (int k = 0; k < 2; k++) begin
      irq_seen = 1'b0;
      drv[k] <= ~drv[k];
      run(k ? 5000 : 1000);
      drv[k] <= ~drv[k];
      run(3400);
      chk(irq_seen, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      wr(`HVW_ADDR_FILTER_MODE, k ? 8'h34 : 8'h24);
      irq_seen = 1'b0;
      drv[2] <= ~drv[2];
      {timer_a_window, timer_b_window} <= k ? 2'b10 : 2'b01; // Wrong timer, as an unpaired output
      run(3400);
      chk(irq_seen, 8'h00);
      rd(`HVW_ADDR_LEVEL_STAT, got);
      chk(got & 8'h07, lvls);
      {timer_a_window, timer_b_window} <= k ? 2'b01 : 2'b10;
      run(3400);
      chk(irq_seen, 8'h01);
      lvls = drv[2:0];
      {timer_a_window, timer_b_window} <= 2'b00;
    end
    wr(`HVW_ADDR_WAKE_STAT1, 8'hFF);
    device_mode <= `HVW_MODE_NORMAL; // Switch may close only in normal mode
    wr(`HVW_ADDR_MEASURE, 8'h01);
    run(4);
    chk(measurement_switch, 8'h01);
    chk(pull_up_on[1:0] | pull_down_on[1:0], 8'h00);
    wr(`HVW_ADDR_PULL_SOURCE, 8'h05);
    rd(`HVW_ADDR_PULL_SOURCE, got);
    chk(got, 8'h05);
    irq_seen = 1'b0;
    drv[0] <= ~drv[0];
    run(3400);
    chk(irq_seen, 8'h00);
    rd(`HVW_ADDR_WAKE_STAT1, got);
    chk(got, 8'h00);
    rd(`HVW_ADDR_LEVEL_STAT, got);
    chk(got & 8'h07, lvls);
    device_mode <= `HVW_MODE_STOP;
    run(3);
    chk(measurement_switch, 8'h00);
    // Sleep with only gated sources fails; adding pin three makes it legal
    for (int k = 0; k < 2; k++) begin
      wr(`HVW_ADDR_WAKE_ENABLE, k ? 8'h07 : 8'h03);
      rst_seen = 1'b0;
      sleep_request <= 1'b1;
      run(1); // Restart pulse stands right after the sampling edge
      sleep_request <= 1'b0;
      run(4);
      chk(rst_seen, k ? 8'h00 : 8'h01);
      chk(cmd_fail_reg, k ? 8'h00 : 8'h01);
      rd(`HVW_ADDR_CMD_STAT, got);
      chk(got & 8'h01, k ? 8'h00 : 8'h01);
      wr(`HVW_ADDR_CMD_STAT, 8'h01);
    end
    report_and_stop();
  end
endmodule
